// ==== rtl/dwa_pkg.sv ====
package dwa_pkg;

    // ------------------------------------------------------------------
    // wiper register layout and values
    // ------------------------------------------------------------------
    localparam int         TAP_LSB        = 0;
    localparam int         TAP_MSB        = 5;
    localparam int         MUTE_BIT       = 6;
    localparam logic [6:0] MUTE_POSITION  = 7'h40;
    localparam logic [7:0] WIPER_RESET    = 8'h3f;

    // ------------------------------------------------------------------
    // serial protocol constants
    // ------------------------------------------------------------------
    localparam logic [3:0] CONTROL_CODE   = 4'h5;
    localparam logic [7:0] CMD_WRITE_ZERO = 8'h01;
    localparam logic [7:0] CMD_WRITE_ONE  = 8'h02;
    localparam logic [7:0] CMD_WRITE_BOTH = 8'h03;
    localparam logic [7:0] CMD_ZC_ON      = 8'h04;
    localparam logic [7:0] CMD_ZC_OFF     = 8'h05;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ          = 125000;
    localparam int PORT_READY_US    = 10;
    localparam int PORT_READY_CYC   = PORT_READY_US * CLK_KHZ / 1000;
    localparam int ZC_TIMEOUT_MS    = 50;
    localparam int ZC_TIMEOUT_CYC   = ZC_TIMEOUT_MS * CLK_KHZ;
    localparam int SYNC_W           = 7;

    typedef enum logic [2:0] {
        dwa_idle,
        dwa_rx,
        dwa_ack,
        dwa_tx,
        dwa_rack
    } dwa_state_t;

endpackage

// ==== rtl/dwa_regs.sv ====
`timescale 1ns/1ps
module dwa_regs
    import dwa_pkg::*;
#(
    parameter int ZC_TIMEOUT = ZC_TIMEOUT_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       chip_select_bit_zero,
    input  wire logic       chip_select_bit_one,
    input  wire logic       chip_select_bit_two,
    input  wire logic       zero_cross_first,
    input  wire logic       zero_cross_second,
    output logic [6:0]      wiper_output_first,
    output logic [6:0]      wiper_output_second,
    output logic            mute_first,
    output logic            mute_second,
    output logic            zc_enabled,
    output logic            port_ready
);

    localparam int TW = $clog2(ZC_TIMEOUT + 1);
    localparam int PW = $clog2(PORT_READY_CYC + 1);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // register byte to tap index, 0..63 or the mute position 64
    function automatic logic [6:0] dwa_tap(input logic [7:0] v);
        if (v[MUTE_BIT]) begin
            return MUTE_POSITION;
        end
        return {1'b0, v[TAP_MSB:TAP_LSB]};
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] sync_c;
    logic              scl_s;
    logic              sda_s;
    logic              scl_d;
    logic              sda_d;
    logic [2:0]        cs_s;
    logic              zc0_s;
    logic              zc1_s;

    // two flops per pin; the third stage only feeds edge detection
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync_a <= '1;
            sync_b <= '1;
            sync_c <= '1;
        end else begin
            sync_a <= {scl_in, sda_in, chip_select_bit_two, chip_select_bit_one,
                       chip_select_bit_zero, zero_cross_second, zero_cross_first};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign scl_s = sync_b[6];
    assign sda_s = sync_b[5];
    assign scl_d = sync_c[6];
    assign sda_d = sync_c[5];
    assign cs_s  = sync_b[4:2];
    assign zc0_s = sync_b[0];
    assign zc1_s = sync_b[1];

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

    // ------------------------------------------------------------------
    // power-up wait
    // ------------------------------------------------------------------
    logic [PW-1:0] ready_cnt;

    // ignore the bus until the port has settled
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ready_cnt  <= '0;
            port_ready <= 1'b0;
        end else if (!port_ready) begin
            ready_cnt  <= ready_cnt + PW'(1);
            port_ready <= (ready_cnt == PW'(PORT_READY_CYC - 1));
        end
    end

    // ------------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------------
    dwa_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic       is_read;
    logic [7:0] cmd;
    logic       master_nack;
    logic       rd_sel;
    logic       wr_strobe;
    logic       cmd_ok;
    logic       addr_ok;
    logic [7:0] rx_byte;
    logic [7:0] wiper_zero_setting;
    logic [7:0] wiper_one_setting;
    logic [7:0] tx_next;
    logic [1:0] strobe_idx;

    assign sda_out = 1'b0;
    assign rx_byte = shift;
    assign addr_ok = (rx_byte[7:4] == CONTROL_CODE) && (rx_byte[3:1] == cs_s);
    assign cmd_ok  = (rx_byte == CMD_WRITE_ZERO) || (rx_byte == CMD_WRITE_ONE) ||
                     (rx_byte == CMD_WRITE_BOTH) || (rx_byte == CMD_ZC_ON) || (rx_byte == CMD_ZC_OFF);
    assign tx_next = rd_sel ? wiper_one_setting : wiper_zero_setting;

    // byte framing, acknowledge and readback shifting
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state       <= dwa_idle;
            bit_cnt     <= '0;
            shift       <= '0;
            byte_idx    <= '0;
            is_read     <= 1'b0;
            cmd         <= '0;
            master_nack <= 1'b0;
            rd_sel      <= 1'b0;
            sda_oe      <= 1'b0;
            wr_strobe   <= 1'b0;
            strobe_idx  <= '0;
        end else begin
            wr_strobe <= 1'b0;
            if (bus_start && port_ready) begin
                state    <= dwa_rx;
                bit_cnt  <= '0;
                byte_idx <= '0;
                rd_sel   <= 1'b0;
                sda_oe   <= 1'b0;
            end else if (bus_stop) begin
                state  <= dwa_idle;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    dwa_idle: begin
                        sda_oe <= 1'b0;
                    end
                    dwa_rx: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= '0;
                            if (byte_idx == 2'd0 && addr_ok) begin
                                is_read <= rx_byte[0];
                                sda_oe  <= 1'b1;
                                state   <= dwa_ack;
                            end else if (byte_idx == 2'd1 && cmd_ok) begin
                                cmd    <= rx_byte;
                                sda_oe <= 1'b1;
                                state  <= dwa_ack;
                            end else if (byte_idx == 2'd2) begin
                                sda_oe <= 1'b1;
                                state  <= dwa_ack;
                            end else begin
                                state <= dwa_idle;
                            end
                        end
                    end
                    dwa_ack: begin
                        if (scl_fall) begin
                            bit_cnt <= '0;
                            if (byte_idx == 2'd0 && is_read) begin
                                shift  <= tx_next;
                                sda_oe <= ~tx_next[7];
                                rd_sel <= ~rd_sel;
                                state  <= dwa_tx;
                            end else begin
                                sda_oe     <= 1'b0;
                                wr_strobe  <= (byte_idx != 2'd0);
                                strobe_idx <= byte_idx;      // byte_idx moves on in this same edge, except when it is already 2
                                state     <= dwa_rx;
                                if (byte_idx != 2'd2) begin
                                    byte_idx <= byte_idx + 2'd1;
                                end
                            end
                        end
                    end
                    dwa_tx: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                state  <= dwa_rack;
                            end else begin
                                shift  <= {shift[6:0], 1'b0};
                                sda_oe <= ~shift[6];
                            end
                        end
                    end
                    dwa_rack: begin
                        if (scl_rise) begin
                            master_nack <= sda_s;
                        end else if (scl_fall) begin
                            bit_cnt <= '0;
                            if (master_nack) begin
                                state <= dwa_idle;
                            end else begin
                                shift  <= tx_next;
                                sda_oe <= ~tx_next[7];
                                rd_sel <= ~rd_sel;
                                state  <= dwa_tx;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // wiper registers and gating mode
    // ------------------------------------------------------------------
    logic data_wr;
    logic wr_zero;
    logic wr_one;

    // the captured index keeps a command acknowledge from writing the wipers
    assign data_wr = wr_strobe && strobe_idx == 2'd2;
    assign wr_zero = data_wr && (cmd == CMD_WRITE_ZERO || cmd == CMD_WRITE_BOTH);
    assign wr_one  = data_wr && (cmd == CMD_WRITE_ONE || cmd == CMD_WRITE_BOTH);

    // full byte kept so readback matches what was written
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wiper_zero_setting <= WIPER_RESET;
            wiper_one_setting  <= WIPER_RESET;
        end else begin
            if (wr_zero) begin
                wiper_zero_setting <= shift;
            end
            if (wr_one) begin
                wiper_one_setting <= shift;
            end
        end
    end

    // mode commands act at the end of their acknowledge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            zc_enabled <= 1'b1;
        end else if (wr_strobe && strobe_idx == 2'd1) begin
            if (cmd == CMD_ZC_ON) begin
                zc_enabled <= 1'b1;
            end else if (cmd == CMD_ZC_OFF) begin
                zc_enabled <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // zero-crossing gated apply
    // ------------------------------------------------------------------
    logic [TW-1:0] zc_timer;
    logic          pend_zero;
    logic          pend_one;
    logic          timed_out;
    logic          apply_zero;
    logic          apply_one;

    assign timed_out  = (zc_timer == TW'(ZC_TIMEOUT));
    assign apply_zero = pend_zero && (!zc_enabled || zc0_s || timed_out);
    assign apply_one  = pend_one && (!zc_enabled || zc1_s || timed_out);

    // one window per write; a new write restarts it for both wipers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            zc_timer  <= '0;
            pend_zero <= 1'b0;
            pend_one  <= 1'b0;
        end else begin
            pend_zero <= wr_zero | (pend_zero & ~apply_zero);   // set wins over the apply
            pend_one  <= wr_one | (pend_one & ~apply_one);
            if (wr_zero || wr_one) begin
                zc_timer <= '0;
            end else if ((pend_zero || pend_one) && !timed_out) begin
                zc_timer <= zc_timer + TW'(1);
            end
        end
    end

    // taps follow the registers only when released by the gate
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wiper_output_first  <= dwa_tap(WIPER_RESET);
            wiper_output_second <= dwa_tap(WIPER_RESET);
            mute_first          <= 1'b0;
            mute_second         <= 1'b0;
        end else begin
            if (apply_zero) begin
                wiper_output_first <= dwa_tap(wiper_zero_setting);
                mute_first         <= wiper_zero_setting[MUTE_BIT];
            end
            if (apply_one) begin
                wiper_output_second <= dwa_tap(wiper_one_setting);
                mute_second         <= wiper_one_setting[MUTE_BIT];
            end
        end
    end

endmodule

// ==== testbench/dwa_regs_properties.sv ====
`timescale 1ns/1ps
module dwa_regs_checker
    import dwa_pkg::*;
#(
    parameter int ZC_TIMEOUT = ZC_TIMEOUT_CYC
) (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       chip_select_bit_zero,
    input wire logic       chip_select_bit_one,
    input wire logic       chip_select_bit_two,
    input wire logic       zero_cross_first,
    input wire logic       zero_cross_second,
    input wire logic [6:0] wiper_output_first,
    input wire logic [6:0] wiper_output_second,
    input wire logic       mute_first,
    input wire logic       mute_second,
    input wire logic       zc_enabled,
    input wire logic       port_ready
);
    // ----------------------------------------
    // start-up wait counter
    // ----------------------------------------
    logic [11:0] wait_cnt;

    // saturates so a port that never opens cannot wrap and look fine
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wait_cnt <= 12'h000;
        end else if (!port_ready && wait_cnt != 12'hfff) begin
            wait_cnt <= wait_cnt + 12'h001;
        end
    end

    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_POS_FIRST: assert property (mute_first == (wiper_output_first == MUTE_POSITION)
        && wiper_output_first <= MUTE_POSITION)
        else $error("first wiper position and mute flag disagree");
    AST_POS_SECOND: assert property (mute_second == (wiper_output_second == MUTE_POSITION)
        && wiper_output_second <= MUTE_POSITION)
        else $error("second wiper position and mute flag disagree");
    AST_RESET_STATE: assert property ($rose(nrst) |-> wiper_output_first == 7'h3f
        && wiper_output_second == 7'h3f && zc_enabled && !port_ready)
        else $error("state after reset is wrong");
    AST_READY_LATE: assert property (!port_ready |-> wait_cnt < 12'h4ec)
        else $error("serial port not ready in time");
    AST_READY_EARLY: assert property ($rose(port_ready) |-> wait_cnt >= 12'h4e0)
        else $error("serial port ready too early");
    AST_READY_HOLD: assert property (port_ready |=> port_ready)
        else $error("port ready dropped");
    AST_QUIET_BEFORE_READY: assert property (!port_ready |-> !sda_oe)
        else $error("data line driven before port ready");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data line changed while clock high");

    cover property (mute_first && mute_second);
    cover property ($rose(sda_oe));
    cover property ($fell(zc_enabled));
endmodule

bind dwa_regs dwa_regs_checker #(.ZC_TIMEOUT(ZC_TIMEOUT)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_bit_zero(chip_select_bit_zero), .chip_select_bit_one(chip_select_bit_one),
    .chip_select_bit_two(chip_select_bit_two), .zero_cross_first(zero_cross_first),
    .zero_cross_second(zero_cross_second), .wiper_output_first(wiper_output_first),
    .wiper_output_second(wiper_output_second), .mute_first(mute_first), .mute_second(mute_second),
    .zc_enabled(zc_enabled), .port_ready(port_ready)
);

// ==== testbench/dwa_bus_master.sv ====
`timescale 1ns/1ps
module dwa_bus_master
    import dwa_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // ----------------------------------------
    // serial controller, 160 ns bit period
    // ----------------------------------------
    // bus idle: both lines released high outside frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic half();
        repeat (10) @(negedge core_clk);
    endtask

    // data moves one cycle after the clock fall so no change is seen with clock high
    task automatic bit_xfer(input logic b, output logic r);
        @(negedge core_clk);
        sda_drv = b;
        repeat (9) @(negedge core_clk);
        scl = 1'b1;
        repeat (5) @(negedge core_clk);
        r = sda_line;
        repeat (5) @(negedge core_clk);
        scl = 1'b0;
    endtask

    task automatic start();
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        @(negedge core_clk);
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // last byte gets a released line, the end-of-read signal
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
    endtask

    // attenuation goes out as the plain binary decibel count
    task automatic write(input logic [2:0] cs, input logic [7:0] cmd, input logic [7:0] d, input logic with_d,
                         output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({CONTROL_CODE, cs, 1'b0}, a0);
        wbyte(cmd, a1);
        a2 = 1'b1;
        if (with_d) wbyte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic read(input logic [2:0] cs, output logic [7:0] w0, output logic [7:0] w1);
        logic a;
        start();
        wbyte({CONTROL_CODE, cs, 1'b1}, a);
        rbyte(1'b0, w0);
        rbyte(1'b1, w1);
        stop();
    endtask
endmodule

// ==== testbench/dual_wiper_attenuator_regs_tb.sv ====
`timescale 1ns/1ps
module dual_wiper_attenuator_regs_tb;
    import dwa_pkg::*;
    typedef struct packed {logic [2:0] cs; logic [7:0] data; logic [6:0] pos;} dwa_row_t;
    localparam dwa_row_t ROWS [8] = '{'{3'h0, 8'h00, 7'h00}, '{3'h1, 8'h06, 7'h06}, '{3'h2, 8'h3f, 7'h3f},
        '{3'h3, 8'h40, 7'h40}, '{3'h4, 8'h80, 7'h00}, '{3'h5, 8'hc5, 7'h40}, '{3'h6, 8'h7f, 7'h40},
        '{3'h7, 8'h21, 7'h21}};

    logic       core_clk, nrst, scl, sda_drv, zc0, zc1, ok;
    logic       sda_out, sda_oe, mute_first, mute_second, zc_enabled, port_ready;
    logic [2:0] cs;
    logic [6:0] w0, w1;
    logic [7:0] r0, r1;
    wire        sda_line = sda_drv & ~(sda_oe & ~sda_out);
    int         num_errors = 0;
    int         tests_run = 0;
    int         cycles = 0;

    dwa_regs #(.ZC_TIMEOUT(200)) dut (.core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_zero(cs[0]), .chip_select_bit_one(cs[1]),
        .chip_select_bit_two(cs[2]), .zero_cross_first(zc0), .zero_cross_second(zc1),
        .wiper_output_first(w0), .wiper_output_second(w1), .mute_first(mute_first),
        .mute_second(mute_second), .zc_enabled(zc_enabled), .port_ready(port_ready));
    dwa_bus_master m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    // ----------------------------------------
    // clock, watchdog, checking
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // the whole run needs about 18000 cycles; near three times that means a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 50000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        cs = 3'h0;
        zc0 = 1'b0;
        zc1 = 1'b0;
        repeat (10) @(negedge core_clk);
        chk("w0 rst", 8'h3f, {1'b0, w0});
        chk("w1 rst", 8'h3f, {1'b0, w1});
        chk("zc rst", 8'h01, {7'h00, zc_enabled});
        nrst = 1'b1;
        for (int k = 0; k < 2000 && port_ready !== 1'b1; k++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        chk("ready", 8'h01, {7'h00, port_ready});
        m.read(3'h0, r0, r1);
        chk("rb0 rst", 8'h3f, r0);
        chk("rb1 rst", 8'h3f, r1);
        m.write(3'h0, CMD_ZC_OFF, 8'h00, 1'b0, ok);
        chk("zc off", 8'h00, {7'h00, zc_enabled});
        // every address, both wipers at once, then read back
        foreach (ROWS[i]) begin
            cs = ROWS[i].cs;
            repeat (4) @(negedge core_clk);
            m.write(cs, CMD_WRITE_BOTH, ROWS[i].data, 1'b1, ok);
            chk("ack", 8'h01, {7'h00, ok});
            chk("w0", {1'b0, ROWS[i].pos}, {1'b0, w0});
            chk("w1", {1'b0, ROWS[i].pos}, {1'b0, w1});
            chk("mute0", {7'h00, ROWS[i].pos == 7'h40}, {7'h00, mute_first});
            chk("mute", {7'h00, ROWS[i].pos == 7'h40}, {7'h00, mute_second});
            m.read(cs, r0, r1);
            chk("rb0", ROWS[i].data, r0);
            chk("rb1", ROWS[i].data, r1);
        end
        // other address and unknown command are refused
        m.write(3'h5, CMD_WRITE_ZERO, 8'h11, 1'b1, ok);
        chk("bad cs", 8'h00, {7'h00, ok});
        m.write(3'h7, 8'h06, 8'h11, 1'b1, ok);
        chk("bad cmd", 8'h00, {7'h00, ok});
        chk("w0 kept", 8'h21, {1'b0, w0});
        m.write(3'h7, CMD_WRITE_ZERO, 8'h0a, 1'b1, ok);
        chk("w0 only", 8'h0a, {1'b0, w0});
        chk("w1 kept", 8'h21, {1'b0, w1});
        m.write(3'h7, CMD_WRITE_ONE, 8'h14, 1'b1, ok);
        chk("w1 only", 8'h14, {1'b0, w1});
        chk("w0 kept2", 8'h0a, {1'b0, w0});
        // gated change waits for a crossing or the timeout
        m.write(3'h7, CMD_ZC_ON, 8'h00, 1'b0, ok);
        chk("zc on", 8'h01, {7'h00, zc_enabled});
        m.write(3'h7, CMD_WRITE_ZERO, 8'h30, 1'b1, ok);
        chk("w0 gated", 8'h0a, {1'b0, w0});
        repeat (200) @(negedge core_clk);
        chk("w0 timeout", 8'h30, {1'b0, w0});
        zc1 = 1'b1;
        m.write(3'h7, CMD_WRITE_ONE, 8'h05, 1'b1, ok);
        chk("w1 crossing", 8'h05, {1'b0, w1});
        zc1 = 1'b0;
        // reset in mid-run must bring back the power-up state
        nrst = 1'b0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        chk("w0 rst2", 8'h3f, {1'b0, w0});
        chk("w1 rst2", 8'h3f, {1'b0, w1});
        chk("zc rst2", 8'h01, {7'h00, zc_enabled});
        chk("ready rst2", 8'h00, {7'h00, port_ready});
        for (int k = 0; k < 2000 && port_ready !== 1'b1; k++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        m.read(3'h7, r0, r1);
        chk("rb0 rst2", 8'h3f, r0);
        chk("rb1 rst2", 8'h3f, r1);
        print_verdict();
    end
endmodule
